// >>> hw/blink_gen.sv
`timescale 1ns/1ps
`default_nettype none
module blink_gen
    import motor_led_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // patterns
    output logic      flash_r,
    output logic      single_r,
    output logic      flicker_r
);

    logic [31:0] pre_r;
    logic        tick;
    logic [7:0]  flash_cnt_r;
    logic [7:0]  single_cnt_r;

    // ********************************************************
    // free-running prescaler
    // ********************************************************
    assign tick = (pre_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pre_r <= 32'h0000_0000;
        else if (tick) pre_r <= 32'h0000_0000;
        else pre_r <= pre_r + 32'h0000_0001; // [RULE_15]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) flicker_r <= 1'b0;
        else if (tick) flicker_r <= ~flicker_r; // [RULE_15]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_cnt_r <= 8'h00;
            flash_r     <= 1'b0;
        end else if (tick) begin
            if (flash_cnt_r == 8'(FLASH_HALF_TICKS - 1)) begin
                flash_cnt_r <= 8'h00;
                flash_r     <= ~flash_r; // [RULE_15]
            end else begin
                flash_cnt_r <= flash_cnt_r + 8'h01;
            end
        end
    end

    // long dark gap keeps single flash apart from plain flashing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            single_cnt_r <= 8'h00;
            single_r     <= 1'b0;
        end else if (tick) begin
            if (single_cnt_r == 8'(SINGLE_PER_TICKS - 1)) single_cnt_r <= 8'h00;
            else single_cnt_r <= single_cnt_r + 8'h01;
            single_r <= (single_cnt_r < 8'(SINGLE_ON_TICKS - 1)) ||
                        (single_cnt_r == 8'(SINGLE_PER_TICKS - 1)); // [RULE_15]
        end
    end

endmodule // blink_gen
`default_nettype wire

// >>> hw/motor_led_pkg.sv
package motor_led_pkg;

    // ********************************************************
    // timing
    // ********************************************************
    localparam int unsigned CLK_KHZ           = 200_000;
    localparam int unsigned TICK_MS           = 50;
    localparam int unsigned TICK_CYC          = TICK_MS * CLK_KHZ;
    localparam int unsigned FLASH_HALF_TICKS  = 4;
    localparam int unsigned SINGLE_ON_TICKS   = 4;
    localparam int unsigned SINGLE_PER_TICKS  = 24;
    localparam int unsigned SYNC_STAGES       = 2;

    // ********************************************************
    // register map
    // ********************************************************
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;

    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [4:0]  IRQ_MASK_RST  = 5'h00;
    localparam int unsigned CTRL_MOTOR_EN = 0;
    localparam int unsigned CTRL_LATCH_A  = 1;
    localparam int unsigned CTRL_LATCH_B  = 2;
    localparam int unsigned CTRL_W        = 3;
    localparam int unsigned STAT_SAFE_BIT = 13;

    localparam int unsigned EV_STATE      = 0;
    localparam int unsigned EV_WARN       = 1;
    localparam int unsigned EV_ERR_A      = 2;
    localparam int unsigned EV_ERR_B      = 3;
    localparam int unsigned EV_SUPPLY     = 4;
    localparam int unsigned NUM_EV        = 5;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [4:0] {
        ESM_INIT  = 5'h01,
        ESM_PREOP = 5'h02,
        ESM_SAFE  = 5'h04,
        ESM_OP    = 5'h08,
        ESM_BOOT  = 5'h10
    } esm_t;

    typedef struct packed {
        logic overtemp;
        logic shorted;
        logic open_load;
    } stage_fault_t;

    typedef struct packed {
        logic       run;
        logic       en_a;
        logic       en_b;
        logic       warn;
        logic       err_a;
        logic       err_b;
        logic       power;
        logic [3:0] enc;
        logic [1:0] din;
    } led_t;

endpackage

// >>> hw/motor_stage_status_leds.sv
// Function
// (RULE_01) The run lamp is dark while the slave is initialising.
// (RULE_02) The run lamp flashes evenly in pre-operational state.
// (RULE_03) Safe-operational state gives single flashes and holds outputs safe.
// (RULE_04) The run lamp is steadily lit in operational state.
// (RULE_05) The run lamp flickers fast in bootstrap state.
// (RULE_06) Enable lamp A is lit only when motor A is enabled and ready.
// (RULE_07) Enable lamp B is lit only when motor B is enabled and ready.
// (RULE_08) The warning lamp lights on missing supply or over 80 degrees.
// (RULE_09) Error lamp A lights on stage A overheat, short or open load.
// (RULE_10) Error lamp B lights on stage B overheat, short or open load.
// (RULE_11) Each encoder track lamp follows its encoder input.
// (RULE_12) Each digital input lamp follows its digital input.
// (RULE_13) Power lamp is lit with supply present and motor control enabled.
// (RULE_14) With encoders fitted, inputs 1 and 2 can trigger latches A and B.
// (RULE_15) All blink patterns come from one free-running prescaler.
`timescale 1ns/1ps
`default_nettype none
module motor_stage_status_leds
    import motor_led_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter bit          HAS_ENCODER = 1'b1,
    parameter int unsigned NUM_ENC     = 4,
    parameter int unsigned NUM_DIN     = 2
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // internal device state
    input  wire esm_t               esm_state,
    input  wire logic               dev_ready,
    input  wire logic               motor_en_a,
    input  wire logic               motor_en_b,
    input  wire logic               temp_warn,
    input  wire stage_fault_t       fault_a,
    input  wire stage_fault_t       fault_b,
    // pins
    input  wire logic               supply_pin,
    input  wire logic [NUM_ENC-1:0] enc_pin,
    input  wire logic [NUM_DIN-1:0] din_pin,
    // outputs
    output led_t                    leds_r,
    output logic                    safe_hold_r,
    output logic                    latch_trig_a_r,
    output logic                    latch_trig_b_r,
    output logic                    irq_r
);

    localparam int unsigned NPIN = 1 + NUM_ENC + NUM_DIN;

    logic [NPIN-1:0]   sync1_r;
    logic [NPIN-1:0]   sync2_r;
    logic              supply_s;
    logic [NUM_ENC-1:0] enc_s;
    logic [NUM_DIN-1:0] din_s;
    logic              flash;
    logic              single;
    logic              flicker;
    logic [CTRL_W-1:0] ctrl_r;
    logic [NUM_EV-1:0] irq_stat_r;
    logic [NUM_EV-1:0] irq_mask_r;
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] irq_stat_nxt;
    logic [NUM_EV-1:0] w1c;
    esm_t              esm_prev_r;
    logic              warn_prev_r;
    logic              err_a_prev_r;
    logic              err_b_prev_r;
    logic              sup_prev_r;
    logic              run_nxt;
    logic              warn_nxt;
    logic              err_a_nxt;
    logic              err_b_nxt;
    logic              acc;
    logic              wr_go;
    logic              rd_go;
    logic              hit;
    logic [31:0]       rd_mux;

    // ********************************************************
    // pattern source
    // ********************************************************
    blink_gen #(.TICK_CYCLES(TICK_CYCLES)) u_blink (
        .pclk      (pclk),
        .presetn   (presetn),
        .flash_r   (flash),
        .single_r  (single),
        .flicker_r (flicker)
    );

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {din_pin, enc_pin, supply_pin};
            sync2_r <= sync1_r;
        end
    end

    assign supply_s = sync2_r[0];
    assign enc_s    = sync2_r[NUM_ENC:1];
    assign din_s    = sync2_r[NPIN-1:NUM_ENC+1];

    // ********************************************************
    // lamp logic
    // ********************************************************
    always_comb begin
        case (esm_state)
            ESM_INIT:  run_nxt = 1'b0;    // [RULE_01]
            ESM_PREOP: run_nxt = flash;   // [RULE_02]
            ESM_SAFE:  run_nxt = single;  // [RULE_03]
            ESM_OP:    run_nxt = 1'b1;    // [RULE_04]
            ESM_BOOT:  run_nxt = flicker; // [RULE_05]
            default:   run_nxt = 1'b0;
        endcase
    end

    assign warn_nxt  = ~supply_s | temp_warn; // [RULE_08]
    assign err_a_nxt = |fault_a;              // [RULE_09]
    assign err_b_nxt = |fault_b;              // [RULE_10]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            leds_r <= '0;
        end else begin
            leds_r.run   <= run_nxt;
            leds_r.en_a  <= motor_en_a & dev_ready; // [RULE_06]
            leds_r.en_b  <= motor_en_b & dev_ready; // [RULE_07]
            leds_r.warn  <= warn_nxt;
            leds_r.err_a <= err_a_nxt;
            leds_r.err_b <= err_b_nxt;
            leds_r.power <= supply_s & ctrl_r[CTRL_MOTOR_EN]; // [RULE_13]
            leds_r.enc   <= enc_s; // [RULE_11]
            leds_r.din   <= din_s; // [RULE_12]
        end
    end

    // outputs held safe in any state short of operational
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) safe_hold_r <= 1'b1;
        else safe_hold_r <= (esm_state != ESM_OP); // [RULE_03]
    end

    // latch triggers only exist on the encoder variant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_trig_a_r <= 1'b0;
            latch_trig_b_r <= 1'b0;
        end else begin
            latch_trig_a_r <= HAS_ENCODER & ctrl_r[CTRL_LATCH_A] & din_s[0]; // [RULE_14]
            latch_trig_b_r <= HAS_ENCODER & ctrl_r[CTRL_LATCH_B] & din_s[1]; // [RULE_14]
        end
    end

    // ********************************************************
    // event detection and interrupt
    // ********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            esm_prev_r   <= ESM_INIT;
            warn_prev_r  <= 1'b0;
            err_a_prev_r <= 1'b0;
            err_b_prev_r <= 1'b0;
            sup_prev_r   <= 1'b0;
        end else begin
            esm_prev_r   <= esm_state;
            warn_prev_r  <= warn_nxt;
            err_a_prev_r <= err_a_nxt;
            err_b_prev_r <= err_b_nxt;
            sup_prev_r   <= supply_s;
        end
    end

    always_comb begin
        ev            = '0;
        ev[EV_STATE]  = (esm_state != esm_prev_r);
        ev[EV_WARN]   = warn_nxt & ~warn_prev_r;
        ev[EV_ERR_A]  = err_a_nxt & ~err_a_prev_r;
        ev[EV_ERR_B]  = err_b_nxt & ~err_b_prev_r;
        ev[EV_SUPPLY] = sup_prev_r & ~supply_s;
    end

    assign w1c = (wr_go && paddr == ADDR_IRQ_STAT) ?
                 pwdata[NUM_EV-1:0] : '0;
    // a new event beats a clear in the same cycle
    assign irq_stat_nxt = (irq_stat_r & ~w1c) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_stat_r <= '0;
        else irq_stat_r <= irq_stat_nxt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_r <= 1'b0;
        else irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // ********************************************************
    // apb slave
    // ********************************************************
    // one wait state so that read data can come from a flop
    assign acc   = psel & penable & ~pready;
    assign wr_go = psel & penable & pready & pwrite;
    assign rd_go = acc & ~pwrite;
    assign hit   = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctrl_r <= CTRL_RST[CTRL_W-1:0];
        else if (wr_go && paddr == ADDR_CTRL) ctrl_r <= pwdata[CTRL_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_mask_r <= IRQ_MASK_RST;
        else if (wr_go && paddr == ADDR_IRQ_MASK) irq_mask_r <= pwdata[NUM_EV-1:0];
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL:     rd_mux[CTRL_W-1:0] = ctrl_r;
            ADDR_STATUS: begin
                rd_mux[$bits(led_t)-1:0] = leds_r;
                rd_mux[STAT_SAFE_BIT]    = safe_hold_r;
            end
            ADDR_IRQ_STAT: rd_mux[NUM_EV-1:0] = irq_stat_r;
            ADDR_IRQ_MASK: rd_mux[NUM_EV-1:0] = irq_mask_r;
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else if (rd_go) prdata <= rd_mux;
        else if (!psel) prdata <= 32'h0000_0000;
    end

    // ********************************************************
    // assertions
    // ********************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_hold_state(esm_t s);
        (esm_state == s) [*2];
    endsequence

    sequence s_apb_write_ctrl;
        psel && penable && pready && pwrite && paddr == ADDR_CTRL;
    endsequence

    AST_RUN_INIT: assert property (s_hold_state(ESM_INIT) |-> !leds_r.run) // [RULE_01]
        else $error("run lamp lit in init");
    AST_RUN_PREOP: assert property (s_hold_state(ESM_PREOP) |-> leds_r.run == $past(flash)) // [RULE_02]
        else $error("run lamp not flashing in preop");
    AST_SAFE_HOLD: assert property (s_hold_state(ESM_SAFE) |-> safe_hold_r && leds_r.run == $past(single)) // [RULE_03]
        else $error("safe state not shown or held");
    AST_RUN_OP: assert property (s_hold_state(ESM_OP) |-> leds_r.run && !safe_hold_r) // [RULE_04]
        else $error("run lamp dark in op");
    AST_RUN_BOOT: assert property (s_hold_state(ESM_BOOT) |-> leds_r.run == $past(flicker)) // [RULE_05]
        else $error("run lamp not flickering in boot");
    AST_EN_A: assert property (1'b1 |=> leds_r.en_a == $past(motor_en_a && dev_ready)) // [RULE_06]
        else $error("enable lamp a wrong");
    AST_EN_B: assert property (1'b1 |=> leds_r.en_b == $past(motor_en_b && dev_ready)) // [RULE_07]
        else $error("enable lamp b wrong");
    AST_ERR: assert property (1'b1 |=> leds_r.err_a == $past(|fault_a) && leds_r.err_b == $past(|fault_b)) // [RULE_09] [RULE_10]
        else $error("error lamp wrong");
    AST_ENC: assert property (1'b1 |=> leds_r.enc == $past(enc_pin, 3)) // [RULE_11]
        else $error("encoder lamp not following pin");
    AST_DIN: assert property (1'b1 |=> leds_r.din == $past(din_pin, 3)) // [RULE_12]
        else $error("input lamp not following pin");
    // with supply present the lamp follows the written enable bit
    AST_POWER: assert property (s_apb_write_ctrl ##1 supply_s |=> leds_r.power == $past(pwdata[CTRL_MOTOR_EN], 2)) // [RULE_13]
        else $error("power lamp wrong");
    AST_POWER_OFF: assert property (!ctrl_r[CTRL_MOTOR_EN] |=> !leds_r.power) // [RULE_13]
        else $error("power lamp lit with motor control blocked");
    AST_SET_WINS: assert property (ev[EV_WARN] && w1c[EV_WARN] |=> irq_stat_r[EV_WARN]) // [RULE_08]
        else $error("warning event lost to clear");
    AST_IRQ: assert property (irq_stat_r[EV_WARN] && irq_mask_r[EV_WARN] |=> irq_r) // [RULE_08]
        else $error("irq missing for warning");

endmodule // motor_stage_status_leds
`default_nettype wire

// >>> sim/lamp_watcher.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// operator model: times the run lamp
// ****************************************
module lamp_watcher (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // lamp seen by the operator
    input  wire logic        lamp,
    // last completed lit and dark spans, in cycles
    output logic      [15:0] on_len,
    output logic      [15:0] off_len
);
    logic        prev_r;
    logic [15:0] cnt_r;

    // spans close on a level change, so a partial first span is reported like any other
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r  <= 1'b0;
            cnt_r   <= 16'h0000;
            on_len  <= 16'h0000;
            off_len <= 16'h0000;
        end else if (lamp != prev_r) begin
            prev_r <= lamp;
            cnt_r  <= 16'h0001;
            if (prev_r) begin
                on_len <= cnt_r;
            end else begin
                off_len <= cnt_r;
            end
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
endmodule // lamp_watcher
`default_nettype wire

// >>> sim/motor_stage_status_leds_tb.sv
`timescale 1ns/1ps
`default_nettype none
module motor_stage_status_leds_tb;
    import motor_led_pkg::*;
    localparam int TK = 4;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;

    logic         pclk = 1'b0, presetn = 1'b0;
    logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata;
    logic         pready, pslverr;
    esm_t         esm_state = ESM_INIT;
    logic         dev_ready = 1'b0, motor_en_a = 1'b0, motor_en_b = 1'b0;
    logic         temp_warn = 1'b0, supply_pin = 1'b1;
    stage_fault_t fault_a = '0, fault_b = '0;
    logic [3:0]   enc_pin = 4'h0;
    logic [1:0]   din_pin = 2'h0;
    led_t         leds_r;
    logic         safe_hold_r, latch_trig_a_r, latch_trig_b_r, irq_r;
    logic [15:0]  on_len, off_len;
    logic [2:0]   ctrl;
    int           n_errors = 0, n_checks = 0, cyc = 0;
    note_t        q[$];

    always #2.5 pclk = ~pclk;

    motor_stage_status_leds #(.TICK_CYCLES(TK)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .esm_state(esm_state),
        .dev_ready(dev_ready), .motor_en_a(motor_en_a),
        .motor_en_b(motor_en_b), .temp_warn(temp_warn), .fault_a(fault_a),
        .fault_b(fault_b), .supply_pin(supply_pin), .enc_pin(enc_pin),
        .din_pin(din_pin), .leds_r(leds_r), .safe_hold_r(safe_hold_r),
        .latch_trig_a_r(latch_trig_a_r), .latch_trig_b_r(latch_trig_b_r),
        .irq_r(irq_r));

    lamp_watcher watch (.pclk(pclk), .presetn(presetn), .lamp(leds_r.run),
        .on_len(on_len), .off_len(off_len));

    // ****************************************
    // checking
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // completion of each transfer is compared against the oldest note
    always @(posedge pclk) begin
        note_t nt;
        if (psel && penable && pready === 1'b1) begin
            if (q.size() == 0) begin
                chk("unexpected transfer", 32'h0000_0000, 32'h0000_0001);
            end else begin
                nt = q.pop_front();
                chk("prdata", nt.d & nt.m, prdata & nt.m);
                chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
            end
        end
    end

    // long enough for every scenario; a hang ends here
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            results();
        end
    end

    // ****************************************
    // apb master
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] m,
                       input logic e);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= w ? d : 32'h0000_0000;
        q.push_back('{d, w ? 32'h0000_0000 : m, e});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        // one wait state: pready is seen at the second access edge
        chk("pready wait", 32'h0000_0002, n);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] status_exp();
        led_t l;
        l.run   = (esm_state == ESM_OP);
        l.en_a  = motor_en_a & dev_ready;
        l.en_b  = motor_en_b & dev_ready;
        l.warn  = ~supply_pin | temp_warn;
        l.err_a = |fault_a;
        l.err_b = |fault_b;
        l.power = supply_pin & ctrl[0];
        l.enc   = enc_pin;
        l.din   = din_pin;
        return {18'h0, (esm_state != ESM_OP), l};
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        esm_t        st[3]  = '{ESM_PREOP, ESM_SAFE, ESM_BOOT};
        int          onx[3] = '{FLASH_HALF_TICKS*TK, SINGLE_ON_TICKS*TK, TK};
        int          ofx[3] = '{FLASH_HALF_TICKS*TK,
                               (SINGLE_PER_TICKS-SINGLE_ON_TICKS)*TK, TK};
        logic [31:0] r;
        void'($urandom(32'ha07d));
        ctrl = 3'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, ADDR_CTRL, CTRL_RST, 32'hffff_ffff, 0);
        apb(0, ADDR_IRQ_MASK, 32'h0, 32'hffff_ffff, 0);
        apb(0, 12'h010, 32'h0, 32'hffff_ffff, 1);
        apb(1, 12'h010, 32'h1234_5678, 32'h0, 1);
        apb(1, ADDR_CTRL, 32'hffff_ffff, 32'h0, 0);
        apb(0, ADDR_CTRL, 32'h0000_0007, 32'hffff_ffff, 0);
        // lamps follow the device state; pins need the sync delay
        repeat (30) begin
            r = $urandom();
            @(posedge pclk);
            {dev_ready, motor_en_a, motor_en_b, temp_warn} <= r[3:0];
            fault_a    <= r[6:4];
            fault_b    <= r[9:7];
            supply_pin <= r[10];
            enc_pin    <= r[14:11];
            din_pin    <= r[16:15];
            ctrl = r[19:17];
            apb(1, ADDR_CTRL, {29'h0, ctrl}, 32'h0, 0);
            repeat (6) @(posedge pclk);
            apb(0, ADDR_STATUS, status_exp(), 32'h0000_3fff, 0);
            chk("latch a", {31'h0, din_pin[0] & ctrl[1]},
                {31'h0, latch_trig_a_r});
            chk("latch b", {31'h0, din_pin[1] & ctrl[2]},
                {31'h0, latch_trig_b_r});
        end
        apb(1, ADDR_STATUS, 32'hffff_ffff, 32'h0, 0);
        apb(0, ADDR_STATUS, status_exp(), 32'h0000_3fff, 0);
        // events: sticky, masked, cleared by writing one
        @(posedge pclk);
        {temp_warn, fault_a, fault_b, supply_pin} <= 8'h01;
        repeat (6) @(posedge pclk);
        apb(1, ADDR_IRQ_MASK, 32'h0, 32'h0, 0);
        apb(1, ADDR_IRQ_STAT, 32'h0000_001f, 32'h0, 0);
        apb(0, ADDR_IRQ_STAT, 32'h0, 32'h0000_001f, 0);
        @(posedge pclk);
        esm_state <= ESM_PREOP;
        fault_a   <= 3'b010;
        repeat (4) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq_r});
        apb(0, ADDR_IRQ_STAT, 32'h0000_0005, 32'h0000_001f, 0);
        apb(1, ADDR_IRQ_MASK, 32'h0000_0001, 32'h0, 0);
        repeat (3) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq_r});
        apb(1, ADDR_IRQ_STAT, 32'h0000_0001, 32'h0, 0);
        repeat (3) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq_r});
        apb(0, ADDR_IRQ_STAT, 32'h0000_0004, 32'h0000_001f, 0);
        // blink patterns timed by the operator model
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            esm_state <= st[i];
            repeat (300) @(posedge pclk);
            chk("run on span", onx[i], {16'h0, on_len});
            chk("run off span", ofx[i], {16'h0, off_len});
            chk("safe hold", 32'h1, {31'h0, safe_hold_r});
        end
        @(posedge pclk);
        esm_state <= ESM_OP;
        repeat (5) @(posedge pclk);
        apb(0, ADDR_STATUS, 32'h0000_1000, 32'h0000_3000, 0);
        repeat (4) @(posedge pclk);
        results();
    end
endmodule // motor_stage_status_leds_tb
`default_nettype wire
